/* File: cct_timer.sv */
// Four-channel capture/compare timer with prescaler and pulse accumulator
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - One 16-bit counter advances on each tick of a seven-stage prescaler.
// R2 - Each of four channels is set independently to capture or compare.
// R3 - Channel three may instead serve as the pulse accumulator.
// R4 - Counter wrap past 16 bits raises an overflow indication.
// R5 - Capture latches the counter on the selected edge of the pin.
// R6 - Compare acts on counter match to drive the pin or flag delays.
// R7 - Sixteen-bit accumulator counts events or gated time, selectable.
// R8 - Capture and compare channels run together from the shared counter.
// R9 - Prescaler divides by 1 to 128 in powers of two, three-bit select.
// R10 - Every event sets its own sticky flag; enabled flags request interrupt.
module cct_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic timer_enable,
  input wire logic [2:0] prescale_sel,
  input wire logic counter_write,
  input wire logic [15:0] counter_wdata,
  input wire cct_pkg::cct_chan_cfg_t chan_cfg [4],
  input wire cct_pkg::cct_pa_cfg_t pa_cfg,
  input wire logic pa_write,
  input wire logic [15:0] pa_wdata,
  input wire cct_pkg::cct_flags_t flag_clear,
  input wire cct_pkg::cct_flags_t flag_enable,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [15:0] counter,
  output logic [15:0] capture [4],
  output logic [15:0] pa_count,
  output cct_pkg::cct_flags_t flags,
  output logic irq
);

  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;
  logic [6:0] presc;
  logic tick;
  logic [3:0] edge_hit;
  logic [3:0] match;
  logic pa_mode;
  logic pa_gate;
  logic pa_step;
  logic pa_wrap;
  logic cnt_wrap;
  cct_pkg::cct_flags_t flag_set;

  // Edge qualifier, shared by capture channels and the accumulator
  // Select code zero matches nothing, so an unused channel stays quiet
  // Both inputs come from the synchroniser, never from the raw pin
  function automatic logic edge_seen(input logic [1:0] sel, input logic now, input logic last);
    edge_seen = ((sel == cct_pkg::EDGE_RISE) && now && !last)
      || ((sel == cct_pkg::EDGE_FALL) && !now && last)
      || ((sel == cct_pkg::EDGE_BOTH) && (now != last));
  endfunction : edge_seen

  // Two-stage synchroniser on the pins; only pin_sync and pin_last are looked at
  // Costs two cycles of latency on every capture and accumulator event
  // Reset level low matches an idle pin, so no false edge after reset
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_last <= 4'h0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Free-running divider; select picks which stage makes the tick
  // Cleared while stopped, so the first tick after enable is predictable
  // Seven stages give divide ratios up to 128
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      presc <= 7'h00;
    else if (!timer_enable)
      presc <= 7'h00;
    else
      presc <= presc + 7'h01; // see R9
  end

  // Tick when all low bits below the chosen stage are ones
  // Select zero leaves the loop empty, so the tick follows the enable
  // The tick is a one-cycle enable; nothing runs on a derived clock
  always_comb
  begin
    tick = timer_enable;
    for (int i = 0; i < 7; i++)
      if (i < int'(prescale_sel))
        tick = tick && presc[i]; // see R9
  end

  // Wrap seen only on a real tick; a software load never reports one
  assign cnt_wrap = tick && (counter == 16'hFFFF) && !counter_write;

  // Main counter; a software write overrides the tick
  // The loaded value counts from the next tick onward
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      counter <= cct_pkg::CNT_RESET;
    else if (counter_write)
      counter <= counter_wdata;
    else if (tick)
      counter <= counter + 16'h0001; // see R1
  end

  assign pa_mode = pa_cfg.enable;
  assign pa_gate = pa_cfg.gate_active_high ? pin_sync[cct_pkg::PA_CH] : !pin_sync[cct_pkg::PA_CH];
  // Gated mode accumulates prescaled time; event mode counts edges
  assign pa_step = pa_mode && (pa_cfg.gated_mode ? (tick && pa_gate)
    : edge_seen(pa_cfg.edge_sel, pin_sync[cct_pkg::PA_CH], pin_last[cct_pkg::PA_CH])); // see R7
  assign pa_wrap = pa_step && (pa_count == 16'hFFFF) && !pa_write;

  // Pulse accumulator register
  // Shares the pin of channel three, which then gives up capture and compare
  // A load overrides a step in the same cycle and hides its wrap
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pa_count <= cct_pkg::CNT_RESET;
    else if (pa_write)
      pa_count <= pa_wdata;
    else if (pa_step)
      pa_count <= pa_count + 16'h0001; // see R7
  end

  // Per-channel capture and compare, all from the one counter
  // Channels never interact; each reads only its own pin and setting, and channel three also the accumulator enable
  // A mix of capture and compare channels runs side by side
  generate
    for (genvar c = 0; c < 4; c++)
    begin : g_chan
      logic owned_by_pa;
      assign owned_by_pa = (c == cct_pkg::PA_CH) && pa_mode; // see R3
      assign edge_hit[c] = !owned_by_pa && !chan_cfg[c].is_compare
        && edge_seen(chan_cfg[c].edge_sel, pin_sync[c], pin_last[c]); // see R2
      // Match only on the tick that lands on the value, so it fires once
      assign match[c] = !owned_by_pa && chan_cfg[c].is_compare && tick
        && (counter + 16'h0001 == chan_cfg[c].compare) && !counter_write; // see R6

      // Capture latch
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
          capture[c] <= cct_pkg::CNT_RESET;
        else if (edge_hit[c])
          capture[c] <= counter; // see R5
      end

      // Compare output pin; driven only in compare mode
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          pin_out[c] <= 1'b0;
          pin_oe[c] <= 1'b0;
        end
        else
        begin
          pin_oe[c] <= !owned_by_pa && chan_cfg[c].is_compare; // see R8
          if (match[c])
            unique case (chan_cfg[c].oc_act)
              cct_pkg::CCT_OC_NONE: pin_out[c] <= pin_out[c];
              cct_pkg::CCT_OC_TOGGLE: pin_out[c] <= !pin_out[c]; // see R6
              cct_pkg::CCT_OC_CLEAR: pin_out[c] <= 1'b0;
              cct_pkg::CCT_OC_SET: pin_out[c] <= 1'b1;
            endcase
        end
      end
    end
  endgenerate

  // Event sources for the sticky flags
  // Gated mode raises no edge flag; its events are time, not pulses
  always_comb
  begin
    flag_set.chan = edge_hit | match;
    flag_set.overflow = cnt_wrap; // see R4
    flag_set.pa_overflow = pa_wrap;
    flag_set.pa_edge = pa_step && !pa_cfg.gated_mode;
  end

  // Sticky flags; a new event beats a clear in the same cycle
  // Losing that race would drop an event software never saw
  // Clear bits act as one-cycle strobes, one for each flag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      flags <= '0;
    else
      flags <= flag_set | (flags & ~flag_clear); // see R10
  end

  // Interrupt request from enabled flags
  // Registered, so it trails the flags by one cycle
  // Level request; it drops only when every enabled flag is cleared
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(flags & flag_enable); // see R10
  end

endmodule : cct_timer
`default_nettype wire

/* File: cct_pkg.sv */
// Package for the four-channel capture/compare timer: constants and carrier types
package cct_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 4;
  localparam int PA_CH = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Per-channel output compare action on match
  typedef enum logic [1:0] {
    CCT_OC_NONE = 2'h0,
    CCT_OC_TOGGLE = 2'h1,
    CCT_OC_CLEAR = 2'h2,
    CCT_OC_SET = 2'h3
  } cct_oc_act_t;

  // Software-side configuration of one channel
  typedef struct packed {
    logic is_compare;
    logic [1:0] edge_sel;
    cct_oc_act_t oc_act;
    logic [CNT_W-1:0] compare;
  } cct_chan_cfg_t;

  // Pulse accumulator configuration
  typedef struct packed {
    logic enable;
    logic gated_mode;
    logic gate_active_high;
    logic [1:0] edge_sel;
  } cct_pa_cfg_t;

  // Sticky status flags seen by software
  typedef struct packed {
    logic [NUM_CH-1:0] chan;
    logic overflow;
    logic pa_overflow;
    logic pa_edge;
  } cct_flags_t;
endpackage : cct_pkg

/* File: cct_checker.sv */
// Port checker for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module cct_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic timer_enable,
  input wire logic [2:0] prescale_sel,
  input wire logic counter_write,
  input wire cct_pkg::cct_chan_cfg_t chan_cfg [4],
  input wire cct_pkg::cct_pa_cfg_t pa_cfg,
  input wire logic pa_write,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [15:0] counter,
  input wire logic [15:0] capture [4],
  input wire logic [15:0] pa_count,
  input wire cct_pkg::cct_flags_t flags
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Counter moves by at most one step unless loaded
  property p_step; !counter_write |=> counter == $past(counter) || counter == $past(counter) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  property p_div1; timer_enable && prescale_sel == 3'h0 && !counter_write |=> counter == $past(counter) + 16'h0001; endproperty
  a_div1: assert property (p_div1) else $error("no tick at divide by one");
  property p_wrap; counter == 16'hFFFF && !counter_write ##1 counter == 16'h0000 |-> flags.overflow; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without overflow flag");
  // A new capture value on channel 0 always comes with its flag
  property p_capflag; capture[0] != $past(capture[0]) |-> flags.chan[0]; endproperty
  a_capflag: assert property (p_capflag) else $error("capture without flag");
  property p_toggle; chan_cfg[1].is_compare && chan_cfg[1].oc_act == cct_pkg::CCT_OC_TOGGLE && counter != $past(counter)
    && counter == chan_cfg[1].compare && !$past(counter_write) |-> pin_out[1] != $past(pin_out[1]); endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match");
  // Skip the edge right after reset, where outputs are still forced low
  property p_oe; !$past(reset) |=> pin_oe[1:0] == $past({chan_cfg[1].is_compare, chan_cfg[0].is_compare}); endproperty
  a_oe: assert property (p_oe) else $error("drive enable mismatch");
  property p_pa; pa_cfg.enable |=> !pin_oe[3]; endproperty
  a_pa: assert property (p_pa) else $error("channel three driven in accumulator mode");
  property p_pacnt; pa_cfg.enable && !pa_cfg.gated_mode && !pa_write |=> pa_count - $past(pa_count) <= 16'h0001; endproperty
  a_pacnt: assert property (p_pacnt) else $error("accumulator jumped");
endmodule : cct_checker
bind cct_timer cct_checker chk (.mclk, .reset, .timer_enable, .prescale_sel, .counter_write, .chan_cfg, .pa_cfg,
  .pa_write, .pin_out, .pin_oe, .counter, .capture, .pa_count, .flags);
`default_nettype wire

/* File: cct_pins.sv */
// Model of the external waveform pins
`timescale 1ns/1ps
`default_nettype none
module cct_pins (
  input wire logic mclk,
  input wire logic [3:0] level,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  // Driven pins read back their own level, others follow the bench
  always @(posedge mclk) pin_in <= (pin_oe & pin_out) | (~pin_oe & level);
endmodule : cct_pins
`default_nettype wire

/* File: test_cct_timer.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module test_cct_timer;
  logic mclk = 0, reset = 1, en = 0, cw = 0, pw = 0, irq;
  logic [2:0] sel = 3'h0;
  logic [15:0] wd = 16'h0000, counter, pa_count;
  logic [3:0] lvl = 4'h0, pin_in, pin_out, pin_oe;
  logic [15:0] capture [4];
  cct_pkg::cct_chan_cfg_t cfg [4] = '{default: '0};
  cct_pkg::cct_pa_cfg_t pa = '0;
  cct_pkg::cct_flags_t fc = '0, fe = '0, flags;
  int bad_count = 0, check_count = 0;
  cct_timer uut (.mclk, .reset, .timer_enable(en), .prescale_sel(sel), .counter_write(cw), .counter_wdata(wd),
    .chan_cfg(cfg), .pa_cfg(pa), .pa_write(pw), .pa_wdata(wd), .flag_clear(fc), .flag_enable(fe), .pin_in,
    .pin_out, .pin_oe, .counter, .capture, .pa_count, .flags, .irq);
  cct_pins pins (.mclk, .level(lvl), .pin_out, .pin_oe, .pin_in);
  initial forever #25 mclk = ~mclk;
  // Reads right after an edge see the values settled by the edge before
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Loads counter and accumulator together
  task load(input logic [15:0] v);
    wd <= v;
    cw <= 1'b1;
    pw <= 1'b1;
    cyc(1);
    cw <= 1'b0;
    pw <= 1'b0;
  endtask : load
  task t_wrap;
    fe.overflow <= 1'b1;
    en <= 1'b1;
    load(16'hFFFD);
    cyc(4);
    chk("counter", 16'h0000, counter);
    chk("overflow", 16'h1, {15'h0, flags.overflow});
    cyc(1);
    chk("irq", 16'h1, {15'h0, irq});
    fc.overflow <= 1'b1;
    cyc(1);
    fc <= '0;
    cyc(2);
    chk("irq", 16'h0, {15'h0, irq});
    $display("wrap done");
  endtask : t_wrap
  // Every divide setting, 256 clocks each
  task t_div;
    for (int s = 0; s < 8; s++)
    begin
      en <= 1'b0;
      sel <= s[2:0];
      load(16'h0000);
      en <= 1'b1;
      cyc(256);
      en <= 1'b0;
      cyc(1);
      chk("ticks", 16'(256 >> s), counter);
    end
    $display("divide done");
  endtask : t_div
  task t_chan;
    cfg[0] <= '{1'b0, cct_pkg::EDGE_RISE, cct_pkg::CCT_OC_NONE, 16'h0000};
    cfg[1] <= '{1'b1, 2'h0, cct_pkg::CCT_OC_TOGGLE, 16'h0040};
    cfg[2] <= '{1'b0, cct_pkg::EDGE_BOTH, cct_pkg::CCT_OC_NONE, 16'h0000};
    pa <= '{1'b1, 1'b0, 1'b1, cct_pkg::EDGE_RISE};
    sel <= 3'h0;
    en <= 1'b1;
    load(16'h0000);
    lvl <= 4'h5;
    cyc(5);
    chk("capture flags", 16'h5, {12'h0, flags.chan & 4'h5});
    chk("capture 0", 16'h0003, capture[0]);
    chk("capture 2", 16'h0003, capture[2]);
    repeat (3)
    begin
      lvl[3] <= 1'b1;
      cyc(3);
      lvl[3] <= 1'b0;
      cyc(3);
    end
    cyc(4);
    chk("events", 16'h0003, pa_count);
    cyc(60);
    chk("compare pin", 16'h1, {15'h0, pin_out[1]});
    chk("compare flag", 16'h1, {15'h0, flags.chan[1]});
    chk("drive enables", 16'h2, {12'h0, pin_oe});
    $display("channels done");
  endtask : t_chan
  // Gated accumulation, falling-edge capture, set and clear actions
  task t_gate;
    cfg[0] <= '{1'b1, 2'h0, cct_pkg::CCT_OC_SET, 16'h0010};
    cfg[1] <= '{1'b1, 2'h0, cct_pkg::CCT_OC_CLEAR, 16'h0020};
    cfg[2] <= '{1'b0, cct_pkg::EDGE_FALL, cct_pkg::CCT_OC_NONE, 16'h0000};
    pa <= '{1'b1, 1'b1, 1'b1, cct_pkg::EDGE_RISE};
    fc <= '1;
    load(16'h0000);
    fc <= '0;
    lvl <= 4'h8;
    cyc(10);
    lvl[3] <= 1'b0;
    cyc(30);
    chk("gated time", 16'h000A, pa_count);
    chk("fall capture", 16'h0003, capture[2]);
    chk("set and clear pins", 16'h1, {14'h0, pin_out[1:0]});
    chk("gate flags", 16'h7, {12'h0, flags.chan});
    chk("no event flag", 16'h0, {15'h0, flags.pa_edge});
    $display("gate done");
  endtask : t_gate
  initial
  begin
    cyc(20);
    reset <= 1'b0;
    cyc(1);
    t_wrap;
    t_div;
    t_chan;
    t_gate;
    close_out;
  end
endmodule : test_cct_timer
`default_nettype wire
